// >>> hw/two_wire_slave_monitor.sv
// Slave receive, slave transmit and bus monitor logic of the two-wire port.
// Assumes firmware on clk drives one-cycle clear and write pulses;
// the link engine runs on link_clk and the pins are open drain.
//
// Summary of operation
// - Compare received address against the left-justified 7-bit own address.
// - With nack select clear, acknowledge the own address positively.
// - Address byte goes to receive buffer at acknowledge time; receive done set.
// - Own or general call address sets the address match flag.
// - Each received data byte sets receive done as acknowledge is driven.
// - Nack select set gives a negative acknowledge on the next byte.
// - STOP while addressed or monitoring sets stop seen; any STOP returns to not-addressed slave.
// - Own address with direction 1 enters slave transmit, still flagged.
// - After byte and acknowledge, set transmit done and capture ack sampled.
// - Every transmitted byte is shifted back into the receive buffer.
// - Negative acknowledge clears transmit direction; firmware writes no more.
// - Clearing transmit done after the final nack sends nothing more.
// - Monitor enabled raises an interrupt for every bus action.
// - Monitoring sets start seen on each START and receives bytes as slave.
// - Monitoring a foreign transfer never drives an acknowledge.
// - Monitoring a foreign transfer never holds the clock low.
// - Monitor enabled while addressed keeps normal modes plus start flag.
// - Monitor disabled flags only own transfers, foreign ones are ignored.
// - After reset the port is a slave receiver.
// - Clearing transmit done in transmit mode loads and sends the buffer.
`timescale 1ns/1ps
`default_nettype none

module two_wire_slave_monitor
  import two_wire_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       link_clk,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            scl_out,
  output logic            scl_oe,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic [7:0] own_address_reg,
  input  wire logic       nack_select,
  input  wire logic       bus_monitor_enable,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_write,
  input  wire logic       rx_done_clear,
  input  wire logic       tx_done_clear,
  input  wire logic       adm_clear,
  input  wire logic       irq_clear,
  input  wire logic       start_clear,
  input  wire logic       stop_clear,
  output logic [7:0]      rx_buffer,
  output logic            rx_done_flag,
  output logic            tx_done_flag,
  output logic            address_match_flag,
  output logic            port_irq_flag,
  output logic            stop_seen_flag,
  output logic            start_seen_flag,
  output logic            ack_sampled,
  output logic            tx_direction
);

  // Link domain
  logic              lrst_a;
  logic              lrst;
  logic              scl;
  logic              sda;
  logic              scl_rise;
  logic              scl_fall;
  logic              start_cond;
  logic              stop_cond;
  link_state_t       state;
  logic [7:0]        shift;
  logic [7:0]        tx_sh;
  logic [3:0]        bit_cnt;
  logic              addressed;
  logic              foreign;
  logic              tx_mode;
  logic              ld_seen;
  logic [10:0]       c1;
  logic [10:0]       c2;
  logic [10:0]       c3;
  logic [ADDR_W-1:0] own_l;
  logic              nack_l;
  logic              mon_l;
  logic              rxd_l;
  logic              load_l;
  logic              addr_hit;
  logic              byte_tg;
  logic              start_tg;
  logic              stop_tg;
  logic [7:0]        ev_data;
  logic              ev_addr;
  logic              ev_match;
  logic              ev_tx;
  logic              ev_ack;
  logic              stop_inv;
  // System domain
  logic [2:0]        t1;
  logic [2:0]        t2;
  logic [2:0]        t3;
  logic [2:0]        t4;
  logic              byte_ev;
  logic              start_ev;
  logic              stop_ev;
  logic [7:0]        tx_buffer;
  logic              await_first;
  logic              load_tg;
  logic              own_read;

  // ==========================================================
  // Link domain reset: asserts at once, releases on link_clk
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      lrst_a <= 1'b1;
      lrst   <= 1'b1;
    end else begin
      lrst_a <= 1'b0;
      lrst   <= lrst_a;
    end
  end

  line_watch u_watch (
    .link_clk   (link_clk),
    .rst        (lrst),
    .scl_in     (scl_in),
    .sda_in     (sda_in),
    .scl        (scl),
    .sda        (sda),
    .scl_rise   (scl_rise),
    .scl_fall   (scl_fall),
    .start_cond (start_cond),
    .stop_cond  (stop_cond)
  );

  // ==========================================================
  // Firmware settings into the link domain, three stages each.
  // Own address is quasi-static: change it only while the bus is idle.
  always_ff @(posedge link_clk or posedge lrst) begin
    if (lrst) begin
      c1 <= CFG_RESET;
      c2 <= CFG_RESET;
      c3 <= CFG_RESET;
    end else begin
      c1 <= {own_address_reg[ADDR_MSB:ADDR_LSB], nack_select, bus_monitor_enable,
             rx_done_flag, load_tg};
      c2 <= c1;
      c3 <= c2;
    end
  end

  assign own_l    = c3[10:4];
  assign nack_l   = c3[3];
  assign mon_l    = c3[2];
  assign rxd_l    = c3[1];
  assign load_l   = c3[0] ^ ld_seen;
  assign addr_hit = (shift[ADDR_MSB:ADDR_LSB] == own_l)
                  | (shift[ADDR_MSB:ADDR_LSB] == GENERAL_CALL);

  // ==========================================================
  // Link engine: bit shifting, acknowledge, clock hold, events.
  // Event payload is written with its toggle and stays put for
  // at least one byte time, long enough for the system side.
  always_ff @(posedge link_clk or posedge lrst) begin
    if (lrst) begin
      state     <= S_IDLE;
      shift     <= BYTE_RESET;
      tx_sh     <= BYTE_RESET;
      bit_cnt   <= CNT_RESET;
      addressed <= 1'b0;
      foreign   <= 1'b0;
      tx_mode   <= 1'b0;
      ld_seen   <= 1'b0;
      sda_oe    <= 1'b0;
      scl_oe    <= 1'b0;
      byte_tg   <= 1'b0;
      start_tg  <= 1'b0;
      stop_tg   <= 1'b0;
      ev_data   <= BYTE_RESET;
      ev_addr   <= 1'b0;
      ev_match  <= 1'b0;
      ev_tx     <= 1'b0;
      ev_ack    <= 1'b0;
      stop_inv  <= 1'b0;
    end else if (stop_cond) begin
      stop_inv  <= addressed | mon_l;
      stop_tg   <= ~stop_tg;
      state     <= S_IDLE;
      addressed <= 1'b0;
      foreign   <= 1'b0;
      tx_mode   <= 1'b0;
      sda_oe    <= 1'b0;
      scl_oe    <= 1'b0;
    end else if (start_cond) begin
      start_tg  <= ~start_tg;
      state     <= S_ADDR;
      bit_cnt   <= CNT_RESET;
      addressed <= 1'b0;
      foreign   <= 1'b0;
      tx_mode   <= 1'b0;
      ld_seen   <= c3[0];  // Drop any stale load request
      sda_oe    <= 1'b0;
      scl_oe    <= 1'b0;
    end else begin
      case (state)
        S_ADDR, S_DATA: begin
          if (scl_rise) begin
            shift   <= {shift[6:0], sda};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == BYTE_BITS) begin
            bit_cnt  <= CNT_RESET;
            ev_data  <= shift;
            ev_addr  <= (state == S_ADDR);
            ev_match <= addr_hit;
            ev_tx    <= 1'b0;
            ev_ack   <= 1'b0;
            if (state == S_ADDR && addr_hit) begin
              addressed <= 1'b1;
              tx_mode   <= shift[RW_BIT];
              sda_oe    <= ~nack_l;
              byte_tg   <= ~byte_tg;
              state     <= S_ACK;
            end else if (state == S_ADDR && !mon_l) begin
              state <= S_IDLE;
            end else begin
              foreign <= foreign | (state == S_ADDR);
              sda_oe  <= addressed & ~nack_l;
              byte_tg <= ~byte_tg;
              state   <= S_ACK;
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            sda_oe <= 1'b0;
            // Only an addressed port may stretch the clock
            if (addressed && (tx_mode || rxd_l)) begin
              scl_oe <= 1'b1;
              state  <= S_HOLD;
            end else begin
              state <= S_DATA;
            end
          end
        end
        S_HOLD: begin
          if (tx_mode ? load_l : !rxd_l) begin
            scl_oe <= 1'b0;
            if (tx_mode) begin
              ld_seen <= c3[0];
              tx_sh   <= tx_buffer;
              sda_oe  <= ~tx_buffer[7];
              state   <= S_TXBIT;
            end else begin
              state <= S_DATA;
            end
          end
        end
        S_TXBIT: begin
          if (scl_rise) begin
            shift <= {shift[6:0], sda};
          end else if (scl_fall) begin
            if (bit_cnt == LAST_BIT) begin
              sda_oe  <= 1'b0;
              bit_cnt <= CNT_RESET;
              state   <= S_TXACK;
            end else begin
              bit_cnt <= bit_cnt + 4'h1;
              tx_sh   <= {tx_sh[6:0], 1'b0};
              sda_oe  <= ~tx_sh[6];
            end
          end
        end
        S_TXACK: begin
          if (scl_rise) begin
            ev_data  <= shift;
            ev_addr  <= 1'b0;
            ev_match <= 1'b0;
            ev_tx    <= 1'b1;
            ev_ack   <= ~sda;
            byte_tg  <= ~byte_tg;
            tx_mode  <= ~sda;
          end else if (scl_fall) begin
            if (tx_mode) begin
              scl_oe <= 1'b1;
              state  <= S_HOLD;
            end else begin
              state <= S_IDLE;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Open-drain pins only ever pull low
  always_ff @(posedge link_clk or posedge lrst) begin
    if (lrst) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end

  // ==========================================================
  // Link events into the system domain: toggle, three stages, compare
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      t1 <= TOGGLE_RESET;
      t2 <= TOGGLE_RESET;
      t3 <= TOGGLE_RESET;
      t4 <= TOGGLE_RESET;
    end else begin
      t1 <= {byte_tg, start_tg, stop_tg};
      t2 <= t1;
      t3 <= t2;
      t4 <= t3;
    end
  end

  assign byte_ev  = t3[2] ^ t4[2];
  assign start_ev = t3[1] ^ t4[1];
  assign stop_ev  = t3[0] ^ t4[0];
  assign own_read = byte_ev & ev_addr & ev_match & ev_data[RW_BIT];

  // ==========================================================
  // Transmit buffer and load requests toward the link
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_buffer   <= BYTE_RESET;
      await_first <= 1'b0;
      load_tg     <= 1'b0;
    end else begin
      if (tx_write)
        tx_buffer <= tx_data;
      if (tx_direction && ((tx_write && await_first) || (tx_done_clear && tx_done_flag)))
        load_tg <= ~load_tg;
      if (own_read)
        await_first <= 1'b1;
      else if (tx_write || start_ev || stop_ev)
        await_first <= 1'b0;
    end
  end

  // ==========================================================
  // Firmware flags: a hardware set wins over a same-cycle clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_buffer          <= BYTE_RESET;
      rx_done_flag       <= 1'b0;
      tx_done_flag       <= 1'b0;
      address_match_flag <= 1'b0;
      ack_sampled        <= 1'b0;
    end else begin
      if (byte_ev)
        rx_buffer <= ev_data;
      rx_done_flag <= (byte_ev & ~ev_tx) | (rx_done_flag & ~rx_done_clear);
      tx_done_flag <= (byte_ev & ev_tx) | (tx_done_flag & ~tx_done_clear);
      address_match_flag <= (byte_ev & ev_addr & ev_match)
                          | (address_match_flag & ~adm_clear);
      if (byte_ev && ev_tx)
        ack_sampled <= ev_ack;
    end
  end

  // Direction, interrupt and bus condition flags
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_direction    <= 1'b0;
      port_irq_flag   <= 1'b0;
      start_seen_flag <= 1'b0;
      stop_seen_flag  <= 1'b0;
    end else begin
      if (own_read)
        tx_direction <= 1'b1;
      else if ((byte_ev && ev_tx && !ev_ack) || stop_ev)
        tx_direction <= 1'b0;
      port_irq_flag <= byte_ev | (start_ev & bus_monitor_enable)
                     | (stop_ev & stop_inv) | (port_irq_flag & ~irq_clear);
      start_seen_flag <= (start_ev & bus_monitor_enable)
                       | (start_seen_flag & ~start_clear);
      stop_seen_flag <= (stop_ev & stop_inv) | (stop_seen_flag & ~stop_clear);
    end
  end

  // ==========================================================
  // Checks
  sequence rx_byte_seq;
    byte_ev && !ev_tx;
  endsequence

  sequence load_req_seq;
    tx_direction && tx_done_flag && tx_done_clear;
  endsequence

  a_rx_flag_set: assert property (@(posedge clk) disable iff (rst)
    rx_byte_seq |=> rx_done_flag && rx_buffer == $past(ev_data))
    else $error("receive byte not flagged");
  a_adm_on_match: assert property (@(posedge clk) disable iff (rst)
    byte_ev && ev_addr && ev_match |=> address_match_flag && port_irq_flag)
    else $error("address match not flagged");
  a_dir_on_read: assert property (@(posedge clk) disable iff (rst)
    own_read |=> tx_direction ##0 await_first)
    else $error("transmit direction not entered");
  a_tx_done_ack: assert property (@(posedge clk) disable iff (rst)
    byte_ev && ev_tx |=> tx_done_flag && ack_sampled == $past(ev_ack))
    else $error("transmit done or ack wrong");
  a_dir_nack_clear: assert property (@(posedge clk) disable iff (rst)
    byte_ev && ev_tx && !ev_ack |=> !tx_direction)
    else $error("direction kept after nack");
  a_load_on_clear: assert property (@(posedge clk) disable iff (rst)
    load_req_seq |=> load_tg != $past(load_tg))
    else $error("clear did not load buffer");
  a_no_send_nack: assert property (@(posedge clk) disable iff (rst)
    !tx_direction && tx_done_clear |=> $stable(load_tg))
    else $error("load issued while receiving");
  a_stop_flag_set: assert property (@(posedge clk) disable iff (rst)
    stop_ev && stop_inv |=> stop_seen_flag && !tx_direction)
    else $error("stop not flagged");
  a_start_mon_only: assert property (@(posedge clk) disable iff (rst)
    $rose(start_seen_flag) |-> $past(bus_monitor_enable) && $past(start_ev))
    else $error("start flagged without monitor");
  a_mon_no_ack: assert property (@(posedge link_clk) disable iff (lrst)
    foreign |-> !sda_oe)
    else $error("ack driven on foreign transfer");
  a_mon_no_stretch: assert property (@(posedge link_clk) disable iff (lrst)
    foreign |-> !scl_oe && !addressed)
    else $error("clock held on foreign transfer");

endmodule

`default_nettype wire

// >>> common/two_wire_pkg.sv
// Shared constants and types for the two-wire slave and bus monitor port.
// Assumes a system clock domain for firmware and a separate link sampling clock.
package two_wire_pkg;

  // ==========================================================
  // Widths and field positions
  localparam int          BYTE_W       = 8;
  localparam int          ADDR_W       = 7;
  localparam int          ADDR_MSB     = 7;   // Own address is left-justified
  localparam int          ADDR_LSB     = 1;
  localparam int          RW_BIT       = 0;   // Direction bit of an address byte
  localparam logic [3:0]  BYTE_BITS    = 4'h8;
  localparam logic [3:0]  LAST_BIT     = 4'h7;

  // ==========================================================
  // Reset values and special codes
  localparam logic [6:0]  GENERAL_CALL = 7'h00;
  localparam logic [7:0]  BYTE_RESET   = 8'h00;
  localparam logic [3:0]  CNT_RESET    = 4'h0;
  localparam logic [1:0]  LINE_IDLE    = 2'h3;  // Both lines idle high
  localparam logic [2:0]  TOGGLE_RESET = 3'h0;
  localparam logic [10:0] CFG_RESET    = 11'h000;

  // ==========================================================
  // Link engine states
  typedef enum logic [6:0] {
    S_IDLE  = 7'h01,
    S_ADDR  = 7'h02,
    S_DATA  = 7'h04,
    S_ACK   = 7'h08,
    S_HOLD  = 7'h10,
    S_TXBIT = 7'h20,
    S_TXACK = 7'h40
  } link_state_t;

endpackage

// >>> hw/line_watch.sv
// Line sampler for the clock and data wires of the two-wire link.
// Assumes raw pin levels in and a free-running link sampling clock.
`timescale 1ns/1ps
`default_nettype none

module line_watch
  import two_wire_pkg::*;
(
  input  wire logic link_clk,
  input  wire logic rst,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_cond,
  output logic      stop_cond
);

  logic [1:0] s1;
  logic [1:0] s2;
  logic [1:0] s3;
  logic [1:0] filt;
  logic [1:0] last;

  // ==========================================================
  // Three-stage synchroniser, bit 0 clock wire, bit 1 data wire
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      s1 <= LINE_IDLE;
      s2 <= LINE_IDLE;
      s3 <= LINE_IDLE;
    end else begin
      s1 <= {sda_in, scl_in};
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A change counts only once the last two stages agree
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_line
      always_ff @(posedge link_clk or posedge rst) begin
        if (rst)
          filt[i] <= 1'b1;
        else if (s2[i] == s3[i])
          filt[i] <= s3[i];
      end
    end
  endgenerate

  // ==========================================================
  // Edge and bus condition detection, all outputs registered
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      last       <= LINE_IDLE;
      scl        <= 1'b1;
      sda        <= 1'b1;
      scl_rise   <= 1'b0;
      scl_fall   <= 1'b0;
      start_cond <= 1'b0;
      stop_cond  <= 1'b0;
    end else begin
      last       <= filt;
      scl        <= filt[0];
      sda        <= filt[1];
      scl_rise   <= filt[0] & ~last[0];
      scl_fall   <= ~filt[0] & last[0];
      start_cond <= filt[0] & last[0] & ~filt[1] & last[1];  // Data falls, clock high
      stop_cond  <= filt[0] & last[0] & filt[1] & ~last[1];  // Data rises, clock high
    end
  end

endmodule

`default_nettype wire

// >>> test/bus_master_model.sv
// Behavioural two-wire bus master that faces the slave port.
// Assumes pull-ups outside: it only pulls a wire low or releases it.
`timescale 1ns/1ps
`default_nettype none

module bus_master_model (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_drv,
  output logic      sda_drv,
  output logic      stretch_timeout
);
  localparam int HALF_NS = 500;  // Clock high phase, far above six link cycles
  localparam int QTR_NS  = 250;  // Data moves well clear of the clock fall

  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
    stretch_timeout = 1'b0;
  end

  // =====================================================
  // Clock high phase; a bounded wait lets the slave stretch
  task automatic clk_high();
    int n;
    n = 0;
    scl_drv = 1'b1;
    while (scl !== 1'b1 && n < 8000) begin
      #10;
      n++;
    end
    if (n == 8000) stretch_timeout = 1'b1;
    #HALF_NS;
  endtask

  // =====================================================
  // Frame edges: START drops data with the clock high; STOP lowers it with the clock low, then raises it with the clock high
  task automatic start_cond();
    sda_drv = 1'b0;
    #HALF_NS;
    scl_drv = 1'b0;
  endtask

  task automatic stop_cond();
    #QTR_NS;
    sda_drv = 1'b0;
    #QTR_NS;
    clk_high();
    sda_drv = 1'b1;
    #HALF_NS;
  endtask

  // Eight bits MSB first, then the ack bit; rx holds the resolved wire levels
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      #QTR_NS;
      sda_drv = tx[i];
      #QTR_NS;
      clk_high();
      rx[i] = sda;
      scl_drv = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// >>> test/test_two_wire_slave_monitor.sv
// Self-checking bench for the two-wire slave and bus monitor port.
// Assumes the bus master model beside it and pull-ups on both wires.
`timescale 1ns/1ps
`default_nettype none

module test_two_wire_slave_monitor;
  import two_wire_pkg::*;
  logic       clk, rst, link_clk, scl_w, sda_w, scl_drv, sda_drv, stretch_timeout;
  logic       scl_out, scl_oe, sda_out, sda_oe, nack_select, bus_monitor_enable, tx_write;
  logic       rx_done_flag, tx_done_flag, address_match_flag, port_irq_flag;
  logic       stop_seen_flag, start_seen_flag, ack_sampled, tx_direction;
  logic [7:0] own_address_reg, tx_data, rx_buffer;
  logic [5:0] clr_all;
  logic [8:0] got;
  int         mismatches, checks;

  // Open-drain wires: low when any party pulls
  assign scl_w = scl_drv & ~scl_oe;
  assign sda_w = sda_drv & ~sda_oe;

  two_wire_slave_monitor two_wire_slave_monitor_inst (
    .clk(clk), .rst(rst), .link_clk(link_clk), .scl_in(scl_w), .sda_in(sda_w),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
    .own_address_reg(own_address_reg), .nack_select(nack_select),
    .bus_monitor_enable(bus_monitor_enable), .tx_data(tx_data), .tx_write(tx_write),
    .rx_done_clear(clr_all[5]), .tx_done_clear(clr_all[4]), .adm_clear(clr_all[3]),
    .irq_clear(clr_all[2]), .start_clear(clr_all[1]), .stop_clear(clr_all[0]),
    .rx_buffer(rx_buffer), .rx_done_flag(rx_done_flag), .tx_done_flag(tx_done_flag),
    .address_match_flag(address_match_flag), .port_irq_flag(port_irq_flag),
    .stop_seen_flag(stop_seen_flag), .start_seen_flag(start_seen_flag),
    .ack_sampled(ack_sampled), .tx_direction(tx_direction));

  bus_master_model bus_master_model_inst (
    .scl(scl_w), .sda(sda_w), .scl_drv(scl_drv), .sda_drv(sda_drv),
    .stretch_timeout(stretch_timeout));

  // =====================================================
  // Clocks; the link clock is offset, yet rising edges of both still meet every 800 ns, first at 375 ns
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #16 link_clk = ~link_clk;
  end

  // =====================================================
  // Checking and closing
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (mismatches == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Bounded wait for a sticky flag; a lost event ends the run
  task automatic wait_set(ref logic f);
    int n;
    n = 0;
    while (f !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (n == 400) begin
      mismatches++;
      summarize();
    end
  endtask

  // Firmware access: optional buffer write, optional clear of every flag
  task automatic fw(input logic [7:0] d, input logic wr, input logic clr);
    @(posedge clk);
    tx_data <= d;
    tx_write <= wr;
    clr_all <= {6{clr}};
    @(posedge clk);
    tx_write <= 1'b0;
    clr_all <= 6'h00;
  endtask

  // =====================================================
  // Main sequence
  initial begin
    mismatches = 0;
    checks = 0;
    rst = 1'b1;
    own_address_reg = 8'hB4;
    nack_select = 1'b0;
    bus_monitor_enable = 1'b0;
    tx_data = 8'h00;
    tx_write = 1'b0;
    clr_all = 6'h00;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    check({tx_direction, rx_done_flag, port_irq_flag, scl_oe, sda_oe}, 9'h000);
    // Own address write, stretch, data acked then refused
    bus_master_model_inst.start_cond();
    bus_master_model_inst.xfer({8'hB4, 1'b1}, got);
    check(got, {8'hB4, 1'b0});
    wait_set(rx_done_flag);
    check({rx_buffer, address_match_flag}, {8'hB4, 1'b1});
    repeat (40) @(posedge clk);
    check({sda_out, scl_out, scl_oe}, 9'h001);
    fw(8'h00, 1'b0, 1'b1);
    bus_master_model_inst.xfer({8'h3C, 1'b1}, got);
    wait_set(rx_done_flag);
    check({rx_buffer, got[0]}, {8'h3C, 1'b0});
    nack_select <= 1'b1;
    fw(8'h00, 1'b0, 1'b1);
    bus_master_model_inst.xfer({8'hC3, 1'b1}, got);
    check(got, {8'hC3, 1'b1});
    nack_select <= 1'b0;
    fw(8'h00, 1'b0, 1'b1);
    bus_master_model_inst.stop_cond();
    wait_set(stop_seen_flag);
    // Own address read: two bytes, the second refused by the master
    fw(8'h00, 1'b0, 1'b1);
    bus_master_model_inst.start_cond();
    bus_master_model_inst.xfer({8'hB5, 1'b1}, got);
    wait_set(rx_done_flag);
    check({rx_buffer, tx_direction}, {8'hB5, 1'b1});
    fw(8'hA5, 1'b1, 1'b1);
    bus_master_model_inst.xfer({8'hFF, 1'b0}, got);
    check(got, {8'hA5, 1'b0});
    wait_set(tx_done_flag);
    check({rx_buffer, ack_sampled}, {8'hA5, 1'b1});
    fw(8'h5A, 1'b1, 1'b1);
    bus_master_model_inst.xfer({8'hFF, 1'b1}, got);
    check(got, {8'h5A, 1'b1});
    wait_set(tx_done_flag);
    check({rx_buffer, ack_sampled}, {8'h5A, 1'b0});
    check({8'h00, tx_direction}, 9'h000);
    fw(8'h00, 1'b0, 1'b1);
    repeat (60) @(posedge clk);
    check({scl_oe, sda_oe, tx_direction}, 9'h000);
    bus_master_model_inst.stop_cond();
    wait_set(stop_seen_flag);
    // General call, then a foreign address ignored with the monitor off
    fw(8'h00, 1'b0, 1'b1);
    bus_master_model_inst.start_cond();
    bus_master_model_inst.xfer({8'h00, 1'b1}, got);
    wait_set(rx_done_flag);
    check({rx_buffer, address_match_flag}, {8'h00, 1'b1});
    fw(8'h00, 1'b0, 1'b1);
    bus_master_model_inst.stop_cond();
    fw(8'h00, 1'b0, 1'b1);
    bus_master_model_inst.start_cond();
    bus_master_model_inst.xfer({8'h40, 1'b1}, got);
    bus_master_model_inst.stop_cond();
    repeat (20) @(posedge clk);
    check({got[0], rx_done_flag, port_irq_flag, stop_seen_flag, start_seen_flag}, 9'h010);
    // Monitor on: foreign transfer is seen but never acked or stretched
    bus_monitor_enable <= 1'b1;
    bus_master_model_inst.start_cond();
    wait_set(start_seen_flag);
    check(port_irq_flag, 9'h001);
    bus_master_model_inst.xfer({8'h40, 1'b1}, got);
    wait_set(rx_done_flag);
    check({rx_buffer, address_match_flag}, {8'h40, 1'b0});
    check(got, {8'h40, 1'b1});
    bus_master_model_inst.xfer({8'h77, 1'b1}, got);
    repeat (40) @(posedge clk);
    check({rx_buffer, scl_oe}, {8'h77, 1'b0});
    bus_master_model_inst.stop_cond();
    wait_set(stop_seen_flag);
    // Monitor on while addressed: normal ack plus the start flag
    fw(8'h00, 1'b0, 1'b1);
    bus_master_model_inst.start_cond();
    bus_master_model_inst.xfer({8'hB4, 1'b1}, got);
    wait_set(rx_done_flag);
    check({got[0], start_seen_flag, address_match_flag}, 9'h003);
    fw(8'h00, 1'b0, 1'b1);
    bus_master_model_inst.stop_cond();
    check(stretch_timeout, 9'h000);
    summarize();
  end
endmodule
`default_nettype wire
